// ---- rtl/dma_peripheral_request_map.sv ----
// dma channel: request source selection, peripheral bus master and dma ram mover

// Function
// [RQ1] Moves a whole block between peripheral register and buffer without software help.
// [RQ2] Transfers use a private bus and ram port; cpu never waits.
// [RQ3] Memory side of every transfer lies inside the dedicated dma ram.
// [RQ4] Codes 00h, 07h, 08h are request-only: interrupt zero, two timers.
// [RQ5] Codes 01h and 05h read capture one and capture two buffers.
// [RQ6] Code 02h writes compare one primary 0182h or secondary 0180h.
// [RQ7] Code 06h writes compare two primary 0188h or secondary 0186h.
// [RQ8] Code 0Ah: first spi done, reads and writes buffer 0248h.
// [RQ9] Code 21h: second spi done, reads and writes buffer 0268h.
// [RQ10] Code 0Bh: first uart receiver, reads 0226h.
// [RQ11] Code 0Ch: first uart transmitter, writes 0224h.
// [RQ12] Code 1Eh: second uart receiver, reads 0236h.
// [RQ13] Code 1Fh: second uart transmitter, writes 0234h.
// [RQ14] Code 0Dh: converter done, reads result buffer 0300h.
// [RQ15] Code 22h: can receive ready, reads 0440h.
// [RQ16] Code 46h: can transmit request, writes 0442h.
// [RQ17] Code 2Dh: parallel port transfer, reads and writes 0608h.
// [RQ18] Code 4Eh: audio right request, writes 03F6h.
// [RQ19] Code 4Fh: audio left request, writes 03F8h.
// [RQ20] Each selected request moves one word between peripheral address and ram pointer.
// [RQ21] Unassigned codes never start; requests from other sources are ignored.
module dma_peripheral_request_map
    import dma_map_pkg::*;
(
    // clock and reset
    input  wire logic               clock,
    input  wire logic               rst,
    // channel setup, sampled on chan_start
    input  wire chan_cfg_s          chan_cfg,
    input  wire logic               chan_start,
    // peripheral request lines, one per source code
    input  wire logic [NUM_SRC-1:0] periph_req,
    // dedicated peripheral bus
    output perbus_req_s             periph_bus,
    input  wire logic [DATA_W-1:0]  periph_rdata,
    input  wire logic               periph_ack,
    // cpu port into dma ram
    input  wire ram_req_s           cpu_req,
    output logic [DATA_W-1:0]       cpu_rdata,
    // status
    output logic                    busy,
    output logic                    block_done,
    output logic                    config_fault,
    output logic [CNT_W-1:0]        words_moved
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        xfer_state_e       st;
        logic              pend;
        logic [CODE_W-1:0] sel;
        logic [ADDR_W-1:0] pad;
        logic              to_periph;
        logic [RAM_AW-1:0] ptr;
        logic [CNT_W-1:0]  left;
        logic [CNT_W-1:0]  total;
        logic [DATA_W-1:0] data;
        perbus_req_s       bus;
        logic              busy;
        logic              done;
        logic              fault;
        logic [CNT_W-1:0]  moved;
    } chan_state_s;

    chan_state_s       s_q;
    chan_state_s       s_d;
    logic              known;
    logic              addr_ok;
    logic              hit;
    logic              take;
    ram_req_s          dma_req;
    logic [DATA_W-1:0] dma_rdata;

    // ------------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------------
    request_source_map u_map (
        .code      (chan_cfg.request_source_code),
        .pad       (chan_cfg.peripheral_address_reg),
        .to_periph (chan_cfg.to_periph),
        .known     (known),
        .addr_ok   (addr_ok)
    );

    // separate ram port so the cpu is never held off by a transfer
    dma_ram u_ram (
        .clock     (clock),
        .rst       (rst),
        .cpu_req   (cpu_req),   // [RQ2]
        .cpu_rdata (cpu_rdata),
        .dma_req   (dma_req),
        .dma_rdata (dma_rdata)
    );

    // ------------------------------------------------------------------
    // request capture: only the latched source counts, set beats clear
    // ------------------------------------------------------------------
    assign hit  = s_q.st != ST_IDLE && periph_req[s_q.sel]; // [RQ21]
    assign take = s_q.st == ST_ARMED && s_q.pend;

    // ram port: read pointer while armed, write after a peripheral read
    always_comb begin
        dma_req.we    = s_q.st == ST_RAM_WR; // memory side is always dma ram [RQ3]
        dma_req.addr  = s_q.ptr;
        dma_req.wdata = s_q.data;
    end

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        s_d.pend = (s_q.pend && !take) || hit;
        case (s_q.st)
            ST_IDLE: begin
                s_d.pend = 1'b0;
                if (chan_start) begin
                    // bad setups are refused, channel stays idle [RQ21]
                    if (known && addr_ok && chan_cfg.count != '0) begin
                        s_d.st        = ST_ARMED;
                        s_d.sel       = chan_cfg.request_source_code;
                        s_d.pad       = chan_cfg.peripheral_address_reg;
                        s_d.to_periph = chan_cfg.to_periph;
                        s_d.ptr       = chan_cfg.ram_start;
                        s_d.left      = chan_cfg.count; // whole block [RQ1]
                        s_d.total     = chan_cfg.count;
                        s_d.moved     = '0;
                        s_d.busy      = 1'b1;
                        s_d.fault     = 1'b0;
                    end else begin
                        s_d.fault = 1'b1;
                    end
                end
            end
            ST_ARMED: begin
                if (take) begin
                    if (s_q.to_periph) begin
                        s_d.st = ST_RAM_RD; // ram data appears next cycle
                    end else begin
                        s_d.st       = ST_PER_RD;
                        s_d.bus.rd   = 1'b1;
                        s_d.bus.addr = s_q.pad; // [RQ20]
                    end
                end
            end
            ST_PER_RD: begin
                if (periph_ack) begin
                    s_d.bus.rd = 1'b0;
                    s_d.data   = periph_rdata;
                    s_d.st     = ST_RAM_WR;
                end
            end
            ST_RAM_WR: begin
                s_d.ptr   = s_q.ptr + 1'b1;
                s_d.left  = s_q.left - 1'b1;
                s_d.moved = s_q.moved + 1'b1;
                s_d.st    = (s_q.left == 11'h001) ? ST_IDLE : ST_ARMED;
                s_d.busy  = s_q.left != 11'h001;
                s_d.done  = s_q.left == 11'h001;
            end
            ST_RAM_RD: begin
                s_d.bus.wr    = 1'b1;
                s_d.bus.addr  = s_q.pad; // [RQ20]
                s_d.bus.wdata = dma_rdata;
                s_d.st        = ST_PER_WR;
            end
            ST_PER_WR: begin
                // strobe holds until the peripheral answers
                if (periph_ack) begin
                    s_d.bus.wr = 1'b0;
                    s_d.ptr    = s_q.ptr + 1'b1;
                    s_d.left   = s_q.left - 1'b1;
                    s_d.moved  = s_q.moved + 1'b1;
                    s_d.st     = (s_q.left == 11'h001) ? ST_IDLE : ST_ARMED;
                    s_d.busy   = s_q.left != 11'h001;
                    s_d.done   = s_q.left == 11'h001; // [RQ1]
                end
            end
            default: begin
                s_d = '0;
            end
        endcase
    end

    // state register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign periph_bus   = s_q.bus;
    assign busy         = s_q.busy;
    assign block_done   = s_q.done;
    assign config_fault = s_q.fault;
    assign words_moved  = s_q.moved;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_UNKNOWN_NEVER_ARMS: assert property ( // [RQ21]
        s_q.st == ST_IDLE && chan_start && !known |=> !busy && config_fault && s_q.st == ST_IDLE
    ) else $error("unassigned code started a channel");

    AST_OTHER_SOURCE_IGNORED: assert property ( // [RQ21]
        s_q.st == ST_ARMED && !s_q.pend && !periph_req[s_q.sel] |=> s_q.st == ST_ARMED
    ) else $error("channel left armed without its own request");

    AST_READ_ONE_WORD: assert property ( // [RQ20]
        s_q.st == ST_PER_RD && periph_ack |=> dma_req.we && dma_req.wdata == $past(periph_rdata)
        ##1 s_q.st inside {ST_ARMED, ST_IDLE}
    ) else $error("peripheral read word not written to dma ram");

    AST_WRITE_FROM_RAM: assert property ( // [RQ20]
        s_q.st == ST_RAM_RD |=> periph_bus.wr && periph_bus.addr == s_q.pad
        && periph_bus.wdata == $past(dma_rdata)
    ) else $error("peripheral write does not carry the ram word");

    AST_STROBE_HOLDS: assert property ( // [RQ20]
        (periph_bus.rd || periph_bus.wr) && !periph_ack |=> $stable(periph_bus)
    ) else $error("bus strobe changed before acknowledge");

    AST_BLOCK_COUNT: assert property ( // [RQ1]
        busy |-> s_q.moved + s_q.left == s_q.total
    ) else $error("moved and remaining words disagree with block size");

    AST_DONE_ENDS_BLOCK: assert property ( // [RQ1]
        block_done |-> !busy && words_moved == s_q.total ##1 !block_done
    ) else $error("block done without full block");

    AST_CAPTURE_ONE_ARMS: assert property ( // [RQ5]
        s_q.st == ST_IDLE && chan_start && chan_cfg.count != '0
        && chan_cfg.request_source_code == SRC_CAPTURE_ONE && !chan_cfg.to_periph
        && chan_cfg.peripheral_address_reg == ADR_CAPTURE_ONE_BUFFER |=> busy
    ) else $error("capture one setup refused");

    AST_COMPARE_WRITE_ONLY: assert property ( // [RQ6]
        s_q.st == ST_IDLE && chan_start
        && chan_cfg.request_source_code == SRC_COMPARE_ONE && !chan_cfg.to_periph |=> config_fault
    ) else $error("compare one accepted as a read source");

    AST_TIMER_REQUEST_ONLY: assert property ( // [RQ4]
        s_q.st == ST_IDLE && chan_start && chan_cfg.count != '0
        && chan_cfg.request_source_code == SRC_SECOND_TIMER |=> busy && !config_fault
    ) else $error("request-only source refused");

    AST_CPU_NOT_STALLED: assert property ( // [RQ2]
        cpu_req.we ##1 !cpu_req.we && cpu_req.addr == $past(cpu_req.addr)
        |=> cpu_rdata == $past(cpu_req.wdata, 2)
    ) else $error("cpu write lost or delayed by a transfer");

    AST_STROBE_ADDR: assert property ( // [RQ20]
        periph_bus.rd || periph_bus.wr
        |-> periph_bus.addr == s_q.pad
    ) else $error("strobe off channel address");

    AST_STROBE_DIRECTION: assert property ( // [RQ20]
        periph_bus.rd || periph_bus.wr
        |-> periph_bus.wr == s_q.to_periph
    ) else $error("strobe against channel direction");

    AST_IDLE_NO_STROBE: assert property ( // [RQ21]
        s_q.st == ST_IDLE
        |-> !periph_bus.rd && !periph_bus.wr
    ) else $error("strobe while idle");

    AST_FAULT_STANDS: assert property ( // [RQ21]
        config_fault && !chan_start
        |=> config_fault
    ) else $error("fault dropped");

    AST_IDLE_DROPS_REQUEST: assert property ( // [RQ21]
        s_q.st == ST_IDLE
        |=> !s_q.pend
    ) else $error("request kept while idle");

    // scenario covers
    COV_READ_BLOCK: cover property (
        s_q.st == ST_RAM_WR && !s_q.to_periph ##1 block_done
    );
    COV_WRITE_BLOCK: cover property (
        s_q.st == ST_PER_WR && periph_ack ##1 block_done
    );
    COV_FAULT: cover property (config_fault);
    COV_BACK_TO_BACK: cover property (take ##[1:6] take);
    COV_STALL: cover property (periph_bus.rd && !periph_ack [*2]);

endmodule

// ---- rtl/dma_map_pkg.sv ----
// package: widths, request source codes, peripheral data addresses and carrier structs
package dma_map_pkg;

    // ------------------------------------------------------------------
    // widths and sizes
    // ------------------------------------------------------------------
    localparam int CODE_W    = 7;
    localparam int ADDR_W    = 16;
    localparam int DATA_W    = 16;
    localparam int RAM_AW    = 10;
    localparam int RAM_DEPTH = 1024;
    localparam int CNT_W     = 11;
    localparam int NUM_SRC   = 128;

    // ------------------------------------------------------------------
    // request source codes
    // ------------------------------------------------------------------
    localparam logic [CODE_W-1:0] SRC_EXT_INT_ZERO   = 7'h00;
    localparam logic [CODE_W-1:0] SRC_CAPTURE_ONE    = 7'h01;
    localparam logic [CODE_W-1:0] SRC_COMPARE_ONE    = 7'h02;
    localparam logic [CODE_W-1:0] SRC_CAPTURE_TWO    = 7'h05;
    localparam logic [CODE_W-1:0] SRC_COMPARE_TWO    = 7'h06;
    localparam logic [CODE_W-1:0] SRC_SECOND_TIMER   = 7'h07;
    localparam logic [CODE_W-1:0] SRC_THIRD_TIMER    = 7'h08;
    localparam logic [CODE_W-1:0] SRC_SPI_ONE_DONE   = 7'h0A;
    localparam logic [CODE_W-1:0] SRC_UART_ONE_RX    = 7'h0B;
    localparam logic [CODE_W-1:0] SRC_UART_ONE_TX    = 7'h0C;
    localparam logic [CODE_W-1:0] SRC_CONVERTER_DONE = 7'h0D;
    localparam logic [CODE_W-1:0] SRC_UART_TWO_RX    = 7'h1E;
    localparam logic [CODE_W-1:0] SRC_UART_TWO_TX    = 7'h1F;
    localparam logic [CODE_W-1:0] SRC_SPI_TWO_DONE   = 7'h21;
    localparam logic [CODE_W-1:0] SRC_CAN_RX_READY   = 7'h22;
    localparam logic [CODE_W-1:0] SRC_PARALLEL_XFER  = 7'h2D;
    localparam logic [CODE_W-1:0] SRC_CAN_TX_REQUEST = 7'h46;
    localparam logic [CODE_W-1:0] SRC_AUDIO_RIGHT    = 7'h4E;
    localparam logic [CODE_W-1:0] SRC_AUDIO_LEFT     = 7'h4F;

    // ------------------------------------------------------------------
    // peripheral data register addresses
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADR_CAPTURE_ONE_BUFFER   = 16'h0140;
    localparam logic [ADDR_W-1:0] ADR_CAPTURE_TWO_BUFFER   = 16'h0144;
    localparam logic [ADDR_W-1:0] ADR_COMPARE_ONE_PRIMARY  = 16'h0182;
    localparam logic [ADDR_W-1:0] ADR_COMPARE_ONE_SECOND   = 16'h0180;
    localparam logic [ADDR_W-1:0] ADR_COMPARE_TWO_PRIMARY  = 16'h0188;
    localparam logic [ADDR_W-1:0] ADR_COMPARE_TWO_SECOND   = 16'h0186;
    localparam logic [ADDR_W-1:0] ADR_FIRST_SPI_BUFFER     = 16'h0248;
    localparam logic [ADDR_W-1:0] ADR_SECOND_SPI_BUFFER    = 16'h0268;
    localparam logic [ADDR_W-1:0] ADR_FIRST_UART_RX_REG    = 16'h0226;
    localparam logic [ADDR_W-1:0] ADR_FIRST_UART_TX_REG    = 16'h0224;
    localparam logic [ADDR_W-1:0] ADR_SECOND_UART_RX_REG   = 16'h0236;
    localparam logic [ADDR_W-1:0] ADR_SECOND_UART_TX_REG   = 16'h0234;
    localparam logic [ADDR_W-1:0] ADR_CONVERTER_RESULT_BUF = 16'h0300;
    localparam logic [ADDR_W-1:0] ADR_CAN_RX_DATA_REG      = 16'h0440;
    localparam logic [ADDR_W-1:0] ADR_CAN_TX_DATA_REG      = 16'h0442;
    localparam logic [ADDR_W-1:0] ADR_PARALLEL_PORT_DATA   = 16'h0608;
    localparam logic [ADDR_W-1:0] ADR_AUDIO_RIGHT_DATA_REG = 16'h03F6;
    localparam logic [ADDR_W-1:0] ADR_AUDIO_LEFT_DATA_REG  = 16'h03F8;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_DATA = 16'h0000;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [CODE_W-1:0] request_source_code;
        logic [ADDR_W-1:0] peripheral_address_reg;
        logic              to_periph;
        logic [RAM_AW-1:0] ram_start;
        logic [CNT_W-1:0]  count;
    } chan_cfg_s;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } perbus_req_s;

    typedef struct packed {
        logic              we;
        logic [RAM_AW-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ram_req_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARMED,
        ST_PER_RD,
        ST_RAM_WR,
        ST_RAM_RD,
        ST_PER_WR
    } xfer_state_e;

endpackage

// ---- rtl/request_source_map.sv ----
// request source code check against the peripheral data address and direction
module request_source_map
    import dma_map_pkg::*;
(
    // channel selection
    input  wire logic [CODE_W-1:0] code,
    input  wire logic [ADDR_W-1:0] pad,
    input  wire logic              to_periph,
    // verdict
    output logic                   known,
    output logic                   addr_ok
);

    // ------------------------------------------------------------------
    // lookup: each data source lists the addresses valid for each direction, request-only sources accept any address
    // ------------------------------------------------------------------
    always_comb begin
        known   = 1'b1;
        addr_ok = 1'b0;
        case (code)
            SRC_EXT_INT_ZERO, SRC_SECOND_TIMER, SRC_THIRD_TIMER: begin
                addr_ok = 1'b1; // request only, no data register [RQ4]
            end
            SRC_CAPTURE_ONE: begin
                addr_ok = !to_periph && pad == ADR_CAPTURE_ONE_BUFFER; // [RQ5]
            end
            SRC_CAPTURE_TWO: begin
                addr_ok = !to_periph && pad == ADR_CAPTURE_TWO_BUFFER; // [RQ5]
            end
            SRC_COMPARE_ONE: begin
                addr_ok = to_periph && (pad == ADR_COMPARE_ONE_PRIMARY
                          || pad == ADR_COMPARE_ONE_SECOND); // [RQ6]
            end
            SRC_COMPARE_TWO: begin
                addr_ok = to_periph && (pad == ADR_COMPARE_TWO_PRIMARY
                          || pad == ADR_COMPARE_TWO_SECOND); // [RQ7]
            end
            SRC_SPI_ONE_DONE: begin
                addr_ok = pad == ADR_FIRST_SPI_BUFFER; // [RQ8]
            end
            SRC_SPI_TWO_DONE: begin
                addr_ok = pad == ADR_SECOND_SPI_BUFFER; // [RQ9]
            end
            SRC_UART_ONE_RX: begin
                addr_ok = !to_periph && pad == ADR_FIRST_UART_RX_REG; // [RQ10]
            end
            SRC_UART_ONE_TX: begin
                addr_ok = to_periph && pad == ADR_FIRST_UART_TX_REG; // [RQ11]
            end
            SRC_UART_TWO_RX: begin
                addr_ok = !to_periph && pad == ADR_SECOND_UART_RX_REG; // [RQ12]
            end
            SRC_UART_TWO_TX: begin
                addr_ok = to_periph && pad == ADR_SECOND_UART_TX_REG; // [RQ13]
            end
            SRC_CONVERTER_DONE: begin
                addr_ok = !to_periph && pad == ADR_CONVERTER_RESULT_BUF; // [RQ14]
            end
            SRC_CAN_RX_READY: begin
                addr_ok = !to_periph && pad == ADR_CAN_RX_DATA_REG; // [RQ15]
            end
            SRC_CAN_TX_REQUEST: begin
                addr_ok = to_periph && pad == ADR_CAN_TX_DATA_REG; // [RQ16]
            end
            SRC_PARALLEL_XFER: begin
                addr_ok = pad == ADR_PARALLEL_PORT_DATA; // [RQ17]
            end
            SRC_AUDIO_RIGHT: begin
                addr_ok = to_periph && pad == ADR_AUDIO_RIGHT_DATA_REG; // [RQ18]
            end
            SRC_AUDIO_LEFT: begin
                addr_ok = to_periph && pad == ADR_AUDIO_LEFT_DATA_REG; // [RQ19]
            end
            default: begin
                known = 1'b0; // unassigned code [RQ21]
            end
        endcase
    end

endmodule

// ---- rtl/dma_ram.sv ----
// dual-port dma ram: cpu port and dedicated controller port, registered read data
module dma_ram
    import dma_map_pkg::*;
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // cpu port
    input  wire ram_req_s          cpu_req,
    output logic [DATA_W-1:0]      cpu_rdata,
    // controller port
    input  wire ram_req_s          dma_req,
    output logic [DATA_W-1:0]      dma_rdata
);

    logic [DATA_W-1:0] mem [RAM_DEPTH];

    // ------------------------------------------------------------------
    // storage: cpu write wins a same-address collision, software owns it
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (dma_req.we && !(cpu_req.we && cpu_req.addr == dma_req.addr)) begin
            mem[dma_req.addr] <= dma_req.wdata;
        end
        if (cpu_req.we) begin
            mem[cpu_req.addr] <= cpu_req.wdata;
        end
    end

    // read registers: each port reads independently, nobody waits
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cpu_rdata <= RST_DATA;
            dma_rdata <= RST_DATA;
        end else begin
            cpu_rdata <= mem[cpu_req.addr];
            dma_rdata <= mem[dma_req.addr];
        end
    end

endmodule

// ---- bench/periph_model.sv ----
// peripheral side model: answers the dedicated bus after a chosen stall and records writes
module periph_model
    import dma_map_pkg::*;
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // dedicated peripheral bus
    input  wire perbus_req_s       periph_bus,
    output logic [DATA_W-1:0]      periph_rdata,
    output logic                   periph_ack,
    // behaviour control and observation
    input  wire logic [1:0]        stall,
    input  wire logic [DATA_W-1:0] rd_word,
    output logic [ADDR_W-1:0]      wr_addr,
    output logic [DATA_W-1:0]      wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_q;

    // the data register is only valid with its acknowledge, so a late sample sees garbage
    assign periph_rdata = periph_ack ? rd_word : ~rd_word;

    // one acknowledge per access, after stall idle cycles of a held strobe
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            periph_ack <= 1'b0;
            wait_q     <= 2'h0;
            wr_addr    <= 16'h0000;
            wr_data    <= 16'h0000;
        end else if (periph_ack) begin
            periph_ack <= 1'b0;
            wait_q     <= 2'h0;
        end else if (periph_bus.rd || periph_bus.wr) begin
            if (wait_q == stall) begin
                periph_ack <= 1'b1;
                wr_addr    <= periph_bus.addr; // reads too
                if (periph_bus.wr) begin
                    wr_data <= periph_bus.wdata;
                end
            end else begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end
endmodule

// ---- bench/dma_peripheral_request_map_tb_top.sv ----
// testbench: source code map, word transfers both ways and refused starts
module dma_peripheral_request_map_tb_top import dma_map_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // signals, clock and instances
    // ------------------------------------------------------------
    logic               clock = 1'b0, rst = 1'b1, chan_start = 1'b0, ack, busy, done, fault;
    chan_cfg_s          cfg = '0;
    logic [NUM_SRC-1:0] req = '0;
    perbus_req_s        bus;
    ram_req_s           cpu = '0;
    logic [DATA_W-1:0]  prd, crd, rd_word = 16'h0000, wa, wd;
    logic [CNT_W-1:0]   moved;
    logic [1:0]         stall = 2'h0;
    int                 bad_count = 0, total_checks = 0, cyc = 0;
    // entries: {to_periph, code, address}
    logic [23:0] tbl [24] = '{24'h00_0000, 24'h07_0000, 24'h88_0000,
        24'h01_0140, 24'h05_0144, 24'h82_0182, 24'h82_0180,
        24'h86_0188, 24'h86_0186, 24'h0A_0248, 24'h8A_0248,
        24'h21_0268, 24'hA1_0268, 24'h0B_0226, 24'h8C_0224,
        24'h1E_0236, 24'h9F_0234, 24'h0D_0300, 24'h22_0440,
        24'hC6_0442, 24'h2D_0608, 24'hAD_0608, 24'hCE_03F6, 24'hCF_03F8};
    always #25 clock = ~clock;
    dma_peripheral_request_map dma_peripheral_request_map_i (.clock(clock), .rst(rst),
        .chan_cfg(cfg), .chan_start(chan_start), .periph_req(req), .periph_bus(bus),
        .periph_rdata(prd), .periph_ack(ack), .cpu_req(cpu), .cpu_rdata(crd), .busy(busy),
        .block_done(done), .config_fault(fault), .words_moved(moved));
    periph_model periph_model_i (.clock(clock), .rst(rst), .periph_bus(bus),
        .periph_rdata(prd), .periph_ack(ack), .stall(stall), .rd_word(rd_word),
        .wr_addr(wa), .wr_data(wd));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic ram_wr(logic [9:0] a, logic [15:0] d);
        @(negedge clock) cpu = '{1'b1, a, d};
        @(negedge clock) cpu.we = 1'b0;
    endtask
    task automatic ram_rd(logic [9:0] a, logic [15:0] exp);
        @(negedge clock) cpu = '{1'b0, a, 16'h0000};
        @(negedge clock) chk("ram", exp, crd);
    endtask
    task automatic start(logic [23:0] e, logic [9:0] base, logic [10:0] n);
        @(negedge clock) cfg = '{e[22:16], e[15:0], e[23], base, n};
        chan_start = 1'b1;
        @(negedge clock) chan_start = 1'b0;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // a refused start raises the fault flag and never becomes busy
    task automatic refuse(logic [23:0] e, logic [10:0] n);
        start(e, 10'h000, n);
        chk("fault", 16'h1, {15'h0, fault});
        chk("busy", 16'h0, {15'h0, busy});
    endtask
    // one block; foreign requests first, then one request per word with varied stalls
    task automatic xfer(logic [23:0] e, logic [9:0] base, logic [10:0] n);
        for (int k = 0; k < n; k++) if (e[23]) ram_wr(10'(base + k), 16'h5A00 + 16'(k));
        start(e, base, n);
        chk("busy", 16'h1, {15'h0, busy});
        chk("fault", 16'h0, {15'h0, fault});
        @(negedge clock) req = ~({{(NUM_SRC-1){1'b0}}, 1'b1} << e[22:16]);
        @(negedge clock) req = '0;
        repeat (4) @(negedge clock);
        chk("moved_foreign", 16'h0, {5'h0, moved});
        for (int k = 0; k < n; k++) begin
            rd_word = 16'hC000 + 16'(base) + 16'(k);
            stall = 2'(k + base[3:2]);
            @(negedge clock) req[e[22:16]] = 1'b1;
            @(negedge clock) req = '0;
            for (int t = 0; t < 20 && moved != 11'(k + 1); t++) @(negedge clock);
            chk("moved", 16'(k + 1), {5'h0, moved});
            chk("wr_addr", e[15:0], wa);
            if (e[23]) chk("wr_data", 16'h5A00 + 16'(k), wd);
        end
        chk("done", 16'h1, {15'h0, done});
        @(negedge clock) chk("busy_end", 16'h0, {15'h0, busy});
        for (int k = 0; k < n; k++)
            if (!e[23]) ram_rd(10'(base + k), 16'hC000 + 16'(base) + 16'(k));
    endtask
    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end
    initial begin
        repeat (6) @(negedge clock);
        rst = 1'b0;
        chk("bus_rst", 16'h0, bus.addr | {14'h0, bus.rd, bus.wr});
        chk("moved_rst", 16'h0, {5'h0, moved} | {15'h0, busy | done | fault});
        refuse(24'h03_0000, 11'h1);
        refuse(24'h01_0142, 11'h1);
        refuse(24'h81_0140, 11'h1);
        refuse(24'h02_0182, 11'h1);
        refuse(24'h0B_0226, 11'h0);
        for (int i = 0; i < 24; i++) xfer(tbl[i], 10'(i * 4), 11'h1);
        xfer(24'h0B_0226, 10'h3FE, 11'h3);
        test_done();
    end
endmodule
